// File: rtl/spc_pkg.sv
package spc_pkg;

   // Register offsets
   localparam logic [7:0] STANDBY_OFS     = 8'h00;
   localparam logic [7:0] BIAS_OFS        = 8'h01;
   localparam logic [7:0] REF_HIGH_OFS    = 8'h10;
   localparam logic [7:0] REF_LOW_OFS     = 8'h11;
   localparam logic [7:0] FB_HIGH_OFS     = 8'h12;
   localparam logic [7:0] FB_LOW_OFS      = 8'h13;
   localparam logic [7:0] PUMP_CTRL_OFS   = 8'h14;
   localparam logic [7:0] ACQ_HIGH_OFS    = 8'h15;
   localparam logic [7:0] ACQ_LOW_OFS     = 8'h16;

   // Values after reset
   localparam logic [7:0] STANDBY_RST     = 8'hff;
   localparam logic [1:0] BIAS_RST        = 2'h0;
   localparam logic [5:0] REF_HIGH_RST    = 6'h00;
   localparam logic [7:0] REF_LOW_RST     = 8'h38;
   localparam logic [4:0] FB_HIGH_RST     = 5'h00;
   localparam logic [7:0] FB_LOW_RST      = 8'h3c;
   localparam logic [7:0] PUMP_CTRL_RST   = 8'h00;
   localparam logic [3:0] ACQ_HIGH_RST    = 4'h0;
   localparam logic [7:0] ACQ_LOW_RST     = 8'h04;

   // Field positions
   localparam int SYNTH_BLOCK_STANDBY_CONTROL_BIT          = 2;
   localparam int OSC_BLOCK_STANDBY_CONTROL_BIT            = 3;
   localparam int BIAS_LSB                = 2;
   localparam int FAST_ENABLE_BIT         = 6;
   localparam int POL_INVERT_BIT          = 5;
   localparam int PUMP_CODE_LSB           = 2;
   localparam int TEST_SEL_LSB            = 0;

   // Divider widths
   localparam int REF_DIV_W               = 14;
   localparam int FB_DIV_W                = 13;
   localparam int ACQ_DIV_W               = 12;

   // Highest pump multiple minus one
   localparam logic [2:0] PUMP_LEVEL_MAX  = 3'h7;

   typedef enum logic [2:0] {
      PFD_IDLE = 3'b001,
      PFD_UP   = 3'b010,
      PFD_DOWN = 3'b100
   } spc_pfd_type;

endpackage

// File: rtl/spc_divider.sv
`timescale 1ns/100ps
module spc_divider #(
   parameter int WIDTH = 14
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Counting
   input  wire logic             count_en,
   input  wire logic             restart,
   input  wire logic [WIDTH-1:0] div_value,
   output logic                  tick_q
);

   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;
   logic             tick_d;
   logic [WIDTH-1:0] last;

   always_comb begin
      // Zero is taken as divide by one
      last   = (div_value == '0) ? '0 : div_value - WIDTH'(1);
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      if (restart) begin
         cnt_d = '0;
      end else if (count_en) begin
         if (cnt_q >= last) begin
            cnt_d  = '0;
            tick_d = 1'b1;
         end else begin
            cnt_d = cnt_q + WIDTH'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

endmodule

// File: rtl/spc_pll_control.sv
`timescale 1ns/100ps
module spc_pll_control (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata_q,
   // Clock inputs, synchronous level samples
   input  wire logic       ref_in,
   input  wire logic       osc_in,
   // Charge pump drive
   output logic            pump_up_q,
   output logic            pump_down_q,
   output logic      [2:0] pump_level_q,
   // Oscillator and static controls
   output logic      [1:0] osc_bias_q,
   output logic            osc_standby_q,
   output logic            synth_standby_q,
   output logic            clock_polarity_invert_q,
   output logic      [1:0] clock_test_select_q
);

   // Register file
   logic [7:0] standby_bits_q,   standby_bits_d;
   logic [1:0] bias_q,           bias_d;
   logic [5:0] ref_high_q,       ref_high_d;
   logic [7:0] ref_low_q,        ref_low_d;
   logic [4:0] fb_high_q,        fb_high_d;
   logic [7:0] fb_low_q,         fb_low_d;
   logic [7:0] pump_ctrl_q,      pump_ctrl_d;
   logic [3:0] acq_high_q,       acq_high_d;
   logic [7:0] acq_low_q,        acq_low_d;
   logic [7:0] reg_rdata_d;

   always_comb begin
      standby_bits_d = standby_bits_q;
      bias_d         = bias_q;
      ref_high_d     = ref_high_q;
      ref_low_d      = ref_low_q;
      fb_high_d      = fb_high_q;
      fb_low_d       = fb_low_q;
      pump_ctrl_d    = pump_ctrl_q;
      acq_high_d     = acq_high_q;
      acq_low_d      = acq_low_q;
      if (reg_wr) begin
         case (reg_addr)
            spc_pkg::STANDBY_OFS:   standby_bits_d = reg_wdata;
            spc_pkg::BIAS_OFS:      bias_d = reg_wdata[spc_pkg::BIAS_LSB +: 2];
            spc_pkg::REF_HIGH_OFS:  ref_high_d = reg_wdata[5:0];
            spc_pkg::REF_LOW_OFS:   ref_low_d = reg_wdata;
            spc_pkg::FB_HIGH_OFS:   fb_high_d = reg_wdata[4:0];
            spc_pkg::FB_LOW_OFS:    fb_low_d = reg_wdata;
            spc_pkg::PUMP_CTRL_OFS: pump_ctrl_d = {1'b0, reg_wdata[6:0]};
            spc_pkg::ACQ_HIGH_OFS:  acq_high_d = reg_wdata[3:0];
            spc_pkg::ACQ_LOW_OFS:   acq_low_d = reg_wdata;
            default:                ;
         endcase
      end
      reg_rdata_d = reg_rdata_q;
      if (reg_rd) begin
         case (reg_addr)
            spc_pkg::STANDBY_OFS:   reg_rdata_d = standby_bits_q;
            spc_pkg::BIAS_OFS:      reg_rdata_d = {4'h0, bias_q, 2'h0};
            spc_pkg::REF_HIGH_OFS:  reg_rdata_d = {2'h0, ref_high_q};
            spc_pkg::REF_LOW_OFS:   reg_rdata_d = ref_low_q;
            spc_pkg::FB_HIGH_OFS:   reg_rdata_d = {3'h0, fb_high_q};
            spc_pkg::FB_LOW_OFS:    reg_rdata_d = fb_low_q;
            spc_pkg::PUMP_CTRL_OFS: reg_rdata_d = pump_ctrl_q;
            spc_pkg::ACQ_HIGH_OFS:  reg_rdata_d = {4'h0, acq_high_q};
            spc_pkg::ACQ_LOW_OFS:   reg_rdata_d = acq_low_q;
            default:                reg_rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         standby_bits_q <= spc_pkg::STANDBY_RST;
         bias_q         <= spc_pkg::BIAS_RST;
         ref_high_q     <= spc_pkg::REF_HIGH_RST;
         ref_low_q      <= spc_pkg::REF_LOW_RST;
         fb_high_q      <= spc_pkg::FB_HIGH_RST;
         fb_low_q       <= spc_pkg::FB_LOW_RST;
         pump_ctrl_q    <= spc_pkg::PUMP_CTRL_RST;
         acq_high_q     <= spc_pkg::ACQ_HIGH_RST;
         acq_low_q      <= spc_pkg::ACQ_LOW_RST;
         reg_rdata_q    <= 8'h00;
      end else begin
         standby_bits_q <= standby_bits_d;
         bias_q         <= bias_d;
         ref_high_q     <= ref_high_d;
         ref_low_q      <= ref_low_d;
         fb_high_q      <= fb_high_d;
         fb_low_q       <= fb_low_d;
         pump_ctrl_q    <= pump_ctrl_d;
         acq_high_q     <= acq_high_d;
         acq_low_q      <= acq_low_d;
         reg_rdata_q    <= reg_rdata_d;
      end
   end

   // Derived controls
   logic [spc_pkg::REF_DIV_W-1:0] ref_divide_value;
   logic [spc_pkg::FB_DIV_W-1:0]  feedback_divide_value;
   logic [spc_pkg::ACQ_DIV_W-1:0] fast_acquire_divisor;
   logic [2:0]                    pump_current_code;
   logic                          fast_acquire_enable;
   logic                          synth_off;

   assign ref_divide_value      = {ref_high_q, ref_low_q};
   assign feedback_divide_value = {fb_high_q, fb_low_q};
   assign fast_acquire_divisor  = {acq_high_q, acq_low_q};
   assign pump_current_code     = pump_ctrl_q[spc_pkg::PUMP_CODE_LSB +: 3];
   assign fast_acquire_enable   = pump_ctrl_q[spc_pkg::FAST_ENABLE_BIT];
   assign synth_off             = standby_bits_q[spc_pkg::SYNTH_BLOCK_STANDBY_CONTROL_BIT];

   // Rising edges of the clock inputs
   logic ref_prev_q, osc_prev_q;
   logic ref_edge,   osc_edge;

   assign ref_edge = ref_in & ~ref_prev_q;
   assign osc_edge = osc_in & ~osc_prev_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ref_prev_q <= 1'b0;
         osc_prev_q <= 1'b0;
      end else begin
         ref_prev_q <= ref_in;
         osc_prev_q <= osc_in;
      end
   end

   // Reference and single integer feedback divider
   logic ref_tick, fb_tick, interval_tick;
   logic pulse_start;

   spc_divider #(.WIDTH(spc_pkg::REF_DIV_W)) u_ref_div (
      .clk       (clk),
      .rstn      (rstn),
      .count_en  (ref_edge),
      .restart   (synth_off),
      .div_value (ref_divide_value),
      .tick_q    (ref_tick)
   );

   spc_divider #(.WIDTH(spc_pkg::FB_DIV_W)) u_fb_div (
      .clk       (clk),
      .rstn      (rstn),
      .count_en  (osc_edge),
      .restart   (synth_off),
      .div_value (feedback_divide_value),
      .tick_q    (fb_tick)
   );

   // Interval timer restarted at each detector pulse
   spc_divider #(.WIDTH(spc_pkg::ACQ_DIV_W)) u_acq_div (
      .clk       (clk),
      .rstn      (rstn),
      .count_en  (ref_edge),
      .restart   (pulse_start | synth_off),
      .div_value (fast_acquire_divisor),
      .tick_q    (interval_tick)
   );

   // Phase/frequency detector and pump level
   spc_pkg::spc_pfd_type pfd_q, pfd_d;
   logic [2:0]           ratio_q, ratio_d;
   logic [2:0]           boost_q, boost_d;
   logic [2:0]           level;
   logic                 pulse_end;

   always_comb begin
      pfd_d       = pfd_q;
      pulse_start = 1'b0;
      pulse_end   = 1'b0;
      case (pfd_q)
         spc_pkg::PFD_IDLE: begin
            if (ref_tick && !fb_tick) begin
               pfd_d       = spc_pkg::PFD_UP;
               pulse_start = 1'b1;
            end else if (fb_tick && !ref_tick) begin
               pfd_d       = spc_pkg::PFD_DOWN;
               pulse_start = 1'b1;
            end
         end
         spc_pkg::PFD_UP: begin
            if (fb_tick) begin
               pfd_d     = spc_pkg::PFD_IDLE;
               pulse_end = 1'b1;
            end
         end
         spc_pkg::PFD_DOWN: begin
            if (ref_tick) begin
               pfd_d     = spc_pkg::PFD_IDLE;
               pulse_end = 1'b1;
            end
         end
         default: pfd_d = spc_pkg::PFD_IDLE;
      endcase
      if (synth_off) begin
         pfd_d = spc_pkg::PFD_IDLE;
      end

      // Whole intervals elapsed in this pulse, saturating
      ratio_d = ratio_q;
      if (pulse_start) begin
         ratio_d = 3'h0;
      end else if (interval_tick && ratio_q != spc_pkg::PUMP_LEVEL_MAX) begin
         ratio_d = ratio_q + 3'h1;
      end

      // Ratio of the finished pulse steers the next one
      boost_d = boost_q;
      if (pulse_end) begin
         boost_d = ratio_q;
      end

      // Level L means current of (L + 1) unit steps
      level = pump_current_code;
      if (fast_acquire_enable) begin
         level = 3'h1;
         if (pump_current_code > level) begin
            level = pump_current_code;
         end
         if (boost_q > level) begin
            level = boost_q;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pfd_q                   <= spc_pkg::PFD_IDLE;
         ratio_q                 <= 3'h0;
         boost_q                 <= 3'h0;
         pump_up_q               <= 1'b0;
         pump_down_q             <= 1'b0;
         pump_level_q            <= 3'h0;
         osc_bias_q              <= spc_pkg::BIAS_RST;
         osc_standby_q           <= 1'b1;
         synth_standby_q         <= 1'b1;
         clock_polarity_invert_q <= 1'b0;
         clock_test_select_q     <= 2'h0;
      end else begin
         pfd_q                   <= pfd_d;
         ratio_q                 <= ratio_d;
         boost_q                 <= boost_d;
         pump_up_q               <= (pfd_d == spc_pkg::PFD_UP);
         pump_down_q             <= (pfd_d == spc_pkg::PFD_DOWN);
         pump_level_q            <= level;
         osc_bias_q              <= bias_q;
         osc_standby_q           <= standby_bits_q[spc_pkg::OSC_BLOCK_STANDBY_CONTROL_BIT];
         synth_standby_q         <= synth_off;
         clock_polarity_invert_q <= pump_ctrl_q[spc_pkg::POL_INVERT_BIT];
         clock_test_select_q     <= pump_ctrl_q[spc_pkg::TEST_SEL_LSB +: 2];
      end
   end

endmodule

// File: dv/spc_props.sv
`timescale 1ns/100ps
module spc_props (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rstn,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata_q,
   // Pump and static outputs
   input wire logic       pump_up_q,
   input wire logic       pump_down_q,
   input wire logic [2:0] pump_level_q,
   input wire logic [1:0] osc_bias_q,
   input wire logic       osc_standby_q,
   input wire logic       synth_standby_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_wr(a);
      reg_wr && reg_addr == a;
   endsequence
   sequence s_rd(a);
      reg_rd && reg_addr == a;
   endsequence
   a_standby_out: assert property (s_wr(8'h00) |-> ##2
      synth_standby_q == $past(reg_wdata[2], 2) && osc_standby_q == $past(reg_wdata[3], 2))
      else $error("standby outputs wrong");
   a_bias_out: assert property (s_wr(8'h01) |-> ##2
      osc_bias_q == $past(reg_wdata[3:2], 2)) else $error("bias output wrong");
   a_bias_read: assert property (s_rd(8'h01) |=>
      reg_rdata_q == {4'h0, osc_bias_q, 2'h0}) else $error("bias readback wrong");
   a_unmapped_read: assert property (reg_rd &&
      !(reg_addr inside {8'h00, 8'h01, [8'h10:8'h16]}) |=> reg_rdata_q == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_q))
      else $error("read data moved");
   a_level_code: assert property (s_wr(8'h14) ##0 !reg_wdata[6] |-> ##2
      (synth_standby_q || pump_level_q == $past(reg_wdata[4:2], 2)))
      else $error("pump level not code");
   a_level_floor: assert property (s_wr(8'h14) ##0 reg_wdata[6] |-> ##2
      (synth_standby_q || pump_level_q >= (($past(reg_wdata[4:2], 2) == 3'h0) ?
      3'h1 : $past(reg_wdata[4:2], 2)))) else $error("boost below nominal");
   a_pump_excl: assert property (!(pump_up_q && pump_down_q))
      else $error("up and down together");
   a_standby_idle: assert property (synth_standby_q && $past(synth_standby_q) |->
      !pump_up_q && !pump_down_q) else $error("pump active in standby");
endmodule
bind spc_pll_control spc_props i_spc_props (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
   .pump_up_q(pump_up_q), .pump_down_q(pump_down_q), .pump_level_q(pump_level_q),
   .osc_bias_q(osc_bias_q), .osc_standby_q(osc_standby_q), .synth_standby_q(synth_standby_q));

// File: dv/spc_vco_model.sv
`timescale 1ns/100ps
module spc_vco_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // Pump drive and scenario knobs
   input  wire logic pump_up,
   input  wire logic pump_down,
   input  wire logic freeze,
   input  wire logic slow,
   // Oscillator
   output logic      osc_in
);
   int   hp;
   int   cnt;
   logic up_d1;
   logic dn_d1;
   logic alt;
   // Loop filter folded into one half-period step per pulse end, or per second pulse end when slow
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hp <= 16;
         cnt <= 0;
         osc_in <= 1'b0;
         up_d1 <= 1'b0;
         dn_d1 <= 1'b0;
         alt <= 1'b0;
      end else begin
         up_d1 <= pump_up;
         dn_d1 <= pump_down;
         if ((up_d1 && !pump_up) || (dn_d1 && !pump_down))
            alt <= ~alt;
         if (!slow || alt) begin
            if (up_d1 && !pump_up && hp > 3)
               hp <= hp - 1;
            if (dn_d1 && !pump_down && hp < 60)
               hp <= hp + 1;
         end
         if (!freeze) begin
            cnt <= (cnt >= hp) ? 1 : cnt + 1;
            if (cnt >= hp)
               osc_in <= ~osc_in;
         end
      end
   end
endmodule

// File: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       ref_in = 1'b0;
   logic       freeze = 1'b0;
   logic       slow = 1'b0;
   logic       ext = 1'b0;
   logic       osc_mod;
   logic [7:0] rdata;
   logic       up;
   logic       dn;
   logic [2:0] level;
   logic       osc_sb;
   logic       syn_sb;
   logic       inv;
   logic [1:0] tsel;
   logic [7:0] exp_q[$];
   logic       pend = 1'b0;
   logic       osc_d1 = 1'b0;
   int         n_fail = 0;
   int         n_tests = 0;
   int         rcnt = 0;
   int         ref_n = 0;
   int         osc_n = 0;
   localparam logic [7:0] ADR[9] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
                                     8'h15, 8'h16};
   localparam logic [7:0] MSK[9] = '{8'hff, 8'h0c, 8'h3f, 8'hff, 8'h1f, 8'hff, 8'h7f,
                                     8'h0f, 8'hff};
   localparam logic [7:0] RST[9] = '{8'hff, 8'h00, 8'h00, 8'h38, 8'h00, 8'h3c, 8'h00,
                                     8'h00, 8'h04};
   spc_pll_control i_spc_pll_control (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata),
      .ref_in(ref_in), .osc_in(ext ? ref_in : osc_mod), .pump_up_q(up), .pump_down_q(dn),
      .pump_level_q(level), .osc_bias_q(), .osc_standby_q(osc_sb), .synth_standby_q(syn_sb),
      .clock_polarity_invert_q(inv), .clock_test_select_q(tsel));
   spc_vco_model i_spc_vco_model (.clk(clk), .rstn(rstn), .pump_up(up), .pump_down(dn),
      .freeze(freeze), .slow(slow), .osc_in(osc_mod));
   always #25 clk = ~clk;
   always @(posedge clk) begin
      rcnt <= (rcnt == 19) ? 0 : rcnt + 1;
      if (rcnt == 19)
         ref_in <= ~ref_in;
      if (rcnt == 19 && !ref_in)
         ref_n <= ref_n + 1;
      osc_d1 <= osc_mod;
      if (osc_mod && !osc_d1)
         osc_n <= osc_n + 1;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      if (pend)
         chk(rdata, exp_q.pop_front());
      pend <= reg_rd;
   end
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      give_verdict;
   end
   initial begin
      int i;
      int k;
      int o0;
      int r0;
      logic [7:0] v;
      k = $urandom(32'h71e06dd8);
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      for (i = 0; i < 9; i++)
         rd(ADR[i], RST[i]);
      rd(8'h05, 8'h00);
      chk({6'h0, syn_sb, osc_sb}, 8'h03);
      $display("Test reset values done");
      for (i = 0; i < 9; i++) begin
         v = 8'($urandom);
         wr(ADR[i], v);
         rd(ADR[i], v & MSK[i]);
         if (i == 6)
            chk({5'h0, inv, tsel}, {5'h0, v[5], v[1:0]});
      end
      wr(8'h20, 8'h5a);
      rd(8'h20, 8'h00);
      $display("Test register access done");
      wr(8'h10, 8'h00);
      wr(8'h11, 8'h02);
      wr(8'h12, 8'h00);
      wr(8'h13, 8'h04);
      wr(8'h15, 8'h00);
      wr(8'h16, 8'h01);
      wr(8'h14, 8'h1c);
      wr(8'h00, 8'hf3);
      repeat (6000) @(posedge clk);
      chk({5'h0, level}, 8'h07);
      o0 = osc_n;
      r0 = ref_n;
      repeat (2000) @(posedge clk);
      k = (osc_n - o0) * 2 - (ref_n - r0) * 4;
      chk(8'(k > 24 || k < -24), 8'h00);
      $display("Test lock ratio done");
      slow <= 1'b1;
      wr(8'h14, 8'h40);
      freeze <= 1'b1;
      repeat (900) @(posedge clk);
      freeze <= 1'b0;
      for (i = 0; i < 2000 && up !== 1'b0; i++)
         @(posedge clk);
      repeat (2) @(posedge clk);
      chk({5'h0, level}, 8'h07);
      $display("Test fast acquire done");
      wr(8'h11, 8'h01);
      wr(8'h13, 8'h01);
      ext <= 1'b1;
      wr(8'h00, 8'hfb);
      repeat (100) @(posedge clk);
      chk({6'h0, syn_sb, osc_sb}, 8'h01);
      k = 0;
      repeat (400) begin
         @(posedge clk);
         k = k + int'(up | dn);
      end
      chk(8'(k), 8'h00);
      wr(8'h00, 8'hff);
      repeat (3) @(posedge clk);
      chk({6'h0, syn_sb, osc_sb}, 8'h03);
      $display("Test external source and standby done");
      give_verdict;
   end
endmodule
